//--- gauge_pkg.sv
package gauge_pkg;
  localparam logic [6:0]  TARGET_ADDR       = 7'h55;
  localparam logic [7:0]  MAX_READ_ADDR     = 8'h7f;
  localparam int          MAP_WORDS         = 29;
  localparam logic [7:0]  OFS_CONTROL_WORD  = 8'h00;
  localparam logic [7:0]  OFS_AT_RATE       = 8'h02;
  localparam logic [7:0]  OFS_UNFILT_SOC    = 8'h04;
  localparam logic [7:0]  OFS_BATT_KELVIN   = 8'h06;
  localparam logic [7:0]  OFS_CELL_MV       = 8'h08;
  localparam logic [7:0]  OFS_CONDITION     = 8'h0a;
  localparam logic [7:0]  OFS_NOM_AVAIL     = 8'h0c;
  localparam logic [7:0]  OFS_FULL_AVAIL    = 8'h0e;
  localparam logic [7:0]  OFS_REMAINING     = 8'h10;
  localparam logic [7:0]  OFS_FULL_CHARGE   = 8'h12;
  localparam logic [7:0]  OFS_AVG_CURRENT   = 8'h14;
  localparam logic [7:0]  OFS_TIME_EMPTY    = 8'h16;
  localparam logic [7:0]  OFS_FILT_FULL     = 8'h18;
  localparam logic [7:0]  OFS_STANDBY_CUR   = 8'h1a;
  localparam logic [7:0]  OFS_UNFILT_FULL   = 8'h1c;
  localparam logic [7:0]  OFS_MAX_LOAD      = 8'h1e;
  localparam logic [7:0]  OFS_UNFILT_REM    = 8'h20;
  localparam logic [7:0]  OFS_FILT_REM      = 8'h22;
  localparam logic [7:0]  OFS_AVG_POWER     = 8'h24;
  localparam logic [7:0]  OFS_DIE_KELVIN    = 8'h28;
  localparam logic [7:0]  OFS_CYCLE_COUNT   = 8'h2a;
  localparam logic [7:0]  OFS_STATE_CHARGE  = 8'h2c;
  localparam logic [7:0]  OFS_STATE_HEALTH  = 8'h2e;
  localparam logic [7:0]  OFS_PASSED_CHARGE = 8'h34;
  localparam logic [7:0]  OFS_DOD_START     = 8'h36;
  localparam logic [7:0]  OFS_SELF_DSG      = 8'h38;
  localparam logic [15:0] RST_WRITABLE      = 16'h0000;
  localparam logic [7:0]  RST_POINTER       = 8'h00;
  localparam longint      CLK_HZ            = 100000000;
  localparam longint      BUS_STUCK_MS      = 2000;
  localparam longint      BUS_STUCK_CYC     = CLK_HZ / 1000 * BUS_STUCK_MS;
  localparam longint      REFRESH_MS        = 1000;
  localparam longint      REFRESH_CYC       = CLK_HZ / 1000 * REFRESH_MS;
  localparam int          WAKE_NS           = 2000;
  localparam int          WAKE_CYC          = (WAKE_NS + 9) / 10;
  localparam int          RA_STRETCH_MS     = 24;
  localparam int          BLOCK_STRETCH_MS  = 72;
  localparam int          RESTORE_STRETCH_MS = 116;
  localparam int          EOD_STRETCH_MS    = 144;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_SLEEP_PLUS, PWR_SLEEP, PWR_HIBERNATE} pwr_mode_t;
endpackage : gauge_pkg

//--- stuck_timer.sv
module stuck_timer
  import gauge_pkg::*;
#(
  parameter longint LIMIT = BUS_STUCK_CYC
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic bus_low,
  output logic      expired
);
  logic [31:0] count_ff;
  wire         at_limit = (count_ff >= 32'(LIMIT - 1));

  // saturates so expiry stays up while the line is still held
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= '0;
      expired  <= 1'b0;
    end else begin
      count_ff <= !bus_low ? '0 : (at_limit ? count_ff : count_ff + 32'd1);
      expired  <= bus_low && at_limit;
    end
  end
endmodule : stuck_timer

//--- gauge_i2c_command_port.sv
module gauge_i2c_command_port
  import gauge_pkg::*;
#(
  parameter longint STUCK_CYC   = BUS_STUCK_CYC,
  parameter longint REFRESH_CYCS = REFRESH_CYC,
  parameter int     WAKE_CYCS   = WAKE_CYC
) (
  input  wire logic               mclk,
  input  wire logic               arst_n,
  input  wire logic               scl_in,
  output logic                    scl_out,
  output logic                    scl_oe,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire pwr_mode_t          pwr_mode,
  input  wire logic               nv_busy,
  input  wire logic [16*MAP_WORDS-1:0] meas_words,
  output logic [15:0]             control_word,
  output logic [15:0]             at_rate_current,
  output logic                    write_strobe,
  output logic                    engine_sleep
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WDATA, ST_WDATA_ACK,
                ST_RDATA, ST_RDATA_ACK, ST_IGNORE} st_t;

  logic [1:0]  scl_sync_ff, sda_sync_ff;
  logic        scl_q_ff, sda_q_ff;
  st_t         st_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  shift_ff, ptr_ff, tx_ff;
  logic        ack_ff, ack_ok_ff, wr_seen_ff, rd_ff;
  logic [15:0] ctrl_ff, rate_ff;
  logic [16*MAP_WORDS-1:0] snap_ff;
  logic [31:0] refresh_ff;
  logic [15:0] wake_ff;
  logic        released_ff, sleep_ff, stb_ff;
  logic        stuck;

  // two flops before any use; edge detection reads only the second
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
    end
  end
  wire scl  = scl_sync_ff[1];
  wire sda  = sda_sync_ff[1];
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl;
      sda_q_ff <= sda;
    end
  end
  wire scl_rise = scl && !scl_q_ff;
  wire scl_fall = !scl && scl_q_ff;
  wire start_c  = scl && scl_q_ff && sda_q_ff && !sda;
  wire stop_c   = scl && scl_q_ff && !sda_q_ff && sda;

  // pair index and byte lane for the pointer
  wire [7:0] byte_in     = {shift_ff[6:0], sda};
  wire [6:0] pair_idx    = ptr_ff[7:1];
  wire       addr_match  = (byte_in[7:1] == TARGET_ADDR);
  wire       ptr_writable = (ptr_ff[7:1] == OFS_CONTROL_WORD[7:1]) ||
                            (ptr_ff[7:1] == OFS_AT_RATE[7:1]);
  // a write runs at most to the end of the writable pair window
  wire       surplus     = wr_seen_ff && ptr_ff[0] == 1'b0 && ptr_ff != OFS_AT_RATE;
  wire [15:0] pair_word  = (ptr_ff[7:1] == OFS_CONTROL_WORD[7:1]) ? ctrl_ff :
                           (ptr_ff[7:1] == OFS_AT_RATE[7:1])      ? rate_ff :
                           (32'(pair_idx) < MAP_WORDS) ? snap_ff[16*pair_idx +: 16] : 16'h0000;
  wire [7:0]  rd_byte    = ptr_ff[0] ? pair_word[15:8] : pair_word[7:0];

  // stretching: sleepy modes wake on every packet, awake modes only on ours
  wire sleepy       = (pwr_mode == PWR_SLEEP) || (pwr_mode == PWR_HIBERNATE);
  wire ours_ack     = (st_ff == ST_ADDR_ACK) || (st_ff == ST_CMD_ACK) ||
                      (st_ff == ST_WDATA_ACK) || (st_ff == ST_RDATA_ACK);
  // wake stretch is timed; once it is over scl stays held only while nv_busy during one of our ack slots
  wire stretch_req  = (wake_ff != 16'd0) ||
                      (nv_busy && ours_ack && !scl);
  wire hold_scl     = stretch_req && !scl && !released_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_ff <= '0;
    end else if (start_c && sleepy) begin
      wake_ff <= 16'(WAKE_CYCS);
    end else if (wake_ff != 16'd0) begin
      wake_ff <= wake_ff - 16'd1;
    end
  end

  stuck_timer #(.LIMIT(STUCK_CYC)) u_stuck (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .bus_low (!scl || !sda),
    .expired (stuck)
  );

  // release drivers then sleep if someone else holds the line
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      released_ff <= 1'b0;
      sleep_ff    <= 1'b0;
    end else begin
      released_ff <= stuck ? 1'b1 : (scl && sda ? 1'b0 : released_ff);
      sleep_ff    <= released_ff && (!scl || !sda);
    end
  end

  // measurement snapshot once per interval
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      refresh_ff <= '0;
      snap_ff    <= '0;
    end else if (refresh_ff >= 32'(REFRESH_CYCS - 1)) begin
      refresh_ff <= '0;
      snap_ff    <= meas_words;
    end else begin
      refresh_ff <= refresh_ff + 32'd1;
    end
  end

  // serial engine
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff      <= ST_IDLE;
      bit_ff     <= '0;
      shift_ff   <= '0;
      ptr_ff     <= RST_POINTER;
      tx_ff      <= '0;
      ack_ff     <= 1'b0;
      ack_ok_ff  <= 1'b0;
      wr_seen_ff <= 1'b0;
      rd_ff      <= 1'b0;
      ctrl_ff    <= RST_WRITABLE;
      rate_ff    <= RST_WRITABLE;
      stb_ff     <= 1'b0;
    end else begin
      stb_ff <= 1'b0;
      if (released_ff) begin
        st_ff  <= ST_IDLE;
        ack_ff <= 1'b0;
      end else if (start_c) begin
        st_ff      <= ST_ADDR;
        bit_ff     <= '0;
        wr_seen_ff <= 1'b0;
      end else if (stop_c) begin
        st_ff  <= ST_IDLE;
        ack_ff <= 1'b0;
      end else begin
        unique case (st_ff)
          ST_IDLE, ST_IGNORE: begin
          end
          ST_ADDR, ST_CMD, ST_WDATA: if (scl_rise) begin
            shift_ff <= byte_in;
            bit_ff   <= bit_ff + 4'd1;
            if (bit_ff == 4'd7) begin
              bit_ff <= '0;
              if (st_ff == ST_ADDR) begin
                rd_ff     <= byte_in[0];
                ack_ok_ff <= addr_match;
                st_ff  <= addr_match ? ST_ADDR_ACK : ST_IGNORE;
              end else if (st_ff == ST_CMD) begin
                ack_ok_ff <= (byte_in <= MAX_READ_ADDR);
                st_ff  <= ST_CMD_ACK;
                if (byte_in <= MAX_READ_ADDR) ptr_ff <= byte_in;
              end else begin
                ack_ok_ff <= ptr_writable && !surplus;
                st_ff  <= ST_WDATA_ACK;
                if (ptr_writable && !surplus) begin
                  stb_ff <= 1'b1;
                  if (ptr_ff[7:1] == OFS_CONTROL_WORD[7:1]) begin
                    if (ptr_ff[0]) ctrl_ff[15:8] <= byte_in;
                    else ctrl_ff[7:0] <= byte_in;
                  end else begin
                    if (ptr_ff[0]) rate_ff[15:8] <= byte_in;
                    else rate_ff[7:0] <= byte_in;
                  end
                end
              end
            end
          end
          // ack goes out after the 8th fall and drops after the 9th, so the
          // target never moves sda while scl is high
          ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: if (scl_fall && bit_ff == 4'd0) begin
            ack_ff <= ack_ok_ff;
            bit_ff <= 4'd1;
          end else if (scl_fall && ack_ok_ff) begin
            ack_ff <= 1'b0;
            bit_ff <= '0;
            if (st_ff == ST_ADDR_ACK && rd_ff) begin
              st_ff <= ST_RDATA;
              tx_ff <= rd_byte;
            end else begin
              st_ff <= (st_ff == ST_ADDR_ACK) ? ST_CMD : ST_WDATA;
              if (st_ff == ST_WDATA_ACK) begin
                ptr_ff     <= ptr_ff + 8'd1;
                wr_seen_ff <= 1'b1;
              end
            end
          end else if (scl_fall) begin
            ack_ff <= 1'b0;
            bit_ff <= '0;
            st_ff  <= ST_IGNORE;
          end
          ST_RDATA: if (scl_fall) begin
            bit_ff <= bit_ff + 4'd1;
            tx_ff  <= {tx_ff[6:0], 1'b0};
            if (bit_ff == 4'd7) begin
              bit_ff <= '0;
              st_ff  <= ST_RDATA_ACK;
            end
          end
          // host ack taken on the rise; next byte loaded only on the fall,
          // otherwise that fall would shift away its first bit
          ST_RDATA_ACK: if (scl_rise && !sda) begin
            ptr_ff <= ptr_ff + 8'd1;
            bit_ff <= 4'd1;
          end else if (scl_rise) begin
            st_ff <= ST_IGNORE;
          end else if (scl_fall && bit_ff == 4'd1) begin
            bit_ff <= '0;
            st_ff  <= ST_RDATA;
            tx_ff  <= rd_byte;
          end
        endcase
      end
    end
  end

  // pins: open drain, drive low only
  wire sda_drive = !released_ff && (ack_ff ||
                   (st_ff == ST_RDATA && !tx_ff[7]));
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe       <= 1'b0;
      scl_oe       <= 1'b0;
      sda_out      <= 1'b0;
      scl_out      <= 1'b0;
      control_word <= RST_WRITABLE;
      at_rate_current <= RST_WRITABLE;
      write_strobe <= 1'b0;
      engine_sleep <= 1'b0;
    end else begin
      sda_oe       <= sda_drive;
      scl_oe       <= hold_scl;
      sda_out      <= 1'b0;
      scl_out      <= 1'b0;
      control_word <= ctrl_ff;
      at_rate_current <= rate_ff;
      write_strobe <= stb_ff;
      engine_sleep <= sleep_ff;
    end
  end

  sequence stuck_seq;
    stuck;
  endsequence
  release_drivers_a: assert property (@(posedge mclk) disable iff (!arst_n)
    stuck_seq |=> ##1 (!sda_oe && !scl_oe)) else $error("drivers kept after stuck bus");
  sleep_entry_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (released_ff && (!scl || !sda)) |-> ##2 engine_sleep) else $error("no sleep");
  cmd_nack_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff == ST_CMD && scl_rise && bit_ff == 4'd7 && byte_in > MAX_READ_ADDR)
    |=> !ack_ok_ff) else $error("high command acked");
  ro_nack_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff == ST_WDATA && scl_rise && bit_ff == 4'd7 && !ptr_writable)
    |=> !ack_ok_ff && $stable(ctrl_ff) && $stable(rate_ff)) else $error("ro write acked");
  addr_match_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff == ST_ADDR && scl_rise && bit_ff == 4'd7 && byte_in[7:1] != TARGET_ADDR)
    |=> st_ff == ST_IGNORE && !ack_ok_ff) else $error("foreign address acked");
  ptr_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff == ST_RDATA_ACK && scl_rise && !sda && !start_c && !stop_c && !released_ff)
    |=> ptr_ff == $past(ptr_ff) + 8'd1) else $error("pointer did not advance");
  wake_stretch_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (start_c && sleepy) |=> wake_ff == 16'(WAKE_CYCS)) else $error("no wake stretch");
  awake_quiet_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!sleepy && !nv_busy && wake_ff == 16'd0) |=> !scl_oe) else $error("stray stretch");
  refresh_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (refresh_ff != 32'(REFRESH_CYCS - 1)) |=> $stable(snap_ff)) else $error("early refresh");
endmodule : gauge_i2c_command_port

//--- i2c_host_model.sv
module i2c_host_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  int timeouts = 0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // waits out any target stretch; bounded so a stuck target is still seen
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 20000) begin
      #10;
      n++;
    end
    if (n == 20000) timeouts++;
    #62.5;
  endtask : rise
  task automatic bit_io(input logic b, output logic s);
    scl_low = 1'b1;
    #40;
    sda_low = !b;
    #22.5;
    rise();
    s = sda;
  endtask : bit_io
  task automatic start();
    scl_low = 1'b1;
    #40;
    sda_low = 1'b0;
    #22.5;
    rise();
    sda_low = 1'b1;
    #62.5;
  endtask : start
  task automatic stop();
    scl_low = 1'b1;
    #40;
    sda_low = 1'b1;
    #22.5;
    rise();
    sda_low = 1'b0;
    #62.5;
  endtask : stop
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : byte_out
  task automatic byte_in(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, s);
  endtask : byte_in
  task automatic hold_sda(input int ns);
    sda_low = 1'b1;
    #(ns);
    sda_low = 1'b0;
  endtask : hold_sda
endmodule : i2c_host_model

//--- gauge_i2c_command_port_tb.sv
module gauge_i2c_command_port_tb
  import gauge_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam longint CYC = 2000;
  logic                   mclk = 1'b0;
  logic                   arst_n = 1'b0;
  logic                   scl_out, scl_oe, sda_out, sda_oe, write_strobe, engine_sleep;
  logic                   scl_low, sda_low, seen;
  pwr_mode_t              pwr_mode = PWR_NORMAL;
  logic                   nv_busy = 1'b0;
  logic [16*MAP_WORDS-1:0] meas_words = '0;
  logic [15:0]            control_word, at_rate_current, w;
  logic [7:0]             ak, a, q[$];
  int                     fails = 0, total_checks = 0, strobes = 0;
  // open-drain lines with pull-ups
  wire scl = !(scl_oe || scl_low);
  wire sda = !(sda_oe || sda_low);
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (scl_oe === 1'b1) seen <= 1'b1;
  always @(posedge mclk) if (write_strobe === 1'b1) strobes++;
  gauge_i2c_command_port #(.STUCK_CYC(CYC), .REFRESH_CYCS(CYC), .WAKE_CYCS(200)) dut (
    .mclk(mclk), .arst_n(arst_n), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .pwr_mode(pwr_mode),
    .nv_busy(nv_busy), .meas_words(meas_words), .control_word(control_word),
    .at_rate_current(at_rate_current), .write_strobe(write_strobe),
    .engine_sleep(engine_sleep));
  i2c_host_model host (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] b[$], output logic [7:0] acks);
    acks = '0;
    host.start();
    foreach (b[i]) host.byte_out(b[i], acks[i]);
    host.stop();
  endtask : wr
  // quick read skips the command phase and uses the live pointer
  task automatic rd(input logic quick, input logic [7:0] cmd, input int n,
                    output logic [7:0] acks, output logic [7:0] d[$]);
    logic [7:0] v;
    acks = '0;
    d = {};
    host.start();
    if (!quick) begin
      host.byte_out(8'haa, acks[0]);
      host.byte_out(cmd, acks[1]);
      host.start();
    end
    host.byte_out(8'hab, acks[2]);
    for (int i = 0; i < n; i++) begin
      host.byte_in(i < n - 1, v);
      d.push_back(v);
    end
    host.stop();
  endtask : rd
  function automatic logic [7:0] exp_byte(input int adr);
    return (adr < 2 * MAP_WORDS) ? meas_words[8*adr +: 8] : 8'h00;
  endfunction : exp_byte
  task automatic print_verdict();
    if (fails == 0 && total_checks > 0 && host.timeouts == 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // full run needs about 180 us of traffic and waits
  initial begin
    #500us;
    fails++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h50b6));
    for (int i = 0; i < MAP_WORDS; i++) meas_words[16*i +: 16] = 16'($urandom);
    tick(3);
    arst_n = 1'b1;
    chk("control_word reset", 16'h0000, control_word);
    chk("at_rate reset", 16'h0000, at_rate_current);
    tick(int'(CYC) + 100);
    strobes = 0;
    w = 16'($urandom);
    wr({8'haa, 8'h02, w[7:0], w[15:8], 8'h5c}, ak);
    chk("at_rate acks", 16'h000f, ak);
    tick(5);
    chk("at_rate value", w, at_rate_current);
    chk("strobe count", 16'd2, 16'(strobes));
    w = 16'($urandom);
    wr({8'haa, 8'h00, w[7:0], w[15:8]}, ak);
    tick(5);
    chk("control acks", 16'h000f, ak);
    chk("control value", w, control_word);
    wr({8'haa, 8'h04 + 8'($urandom_range(0, 50)), 8'h33}, ak);
    chk("ro write acks", 16'h0003, ak);
    wr({8'haa, 8'h80 + 8'($urandom_range(0, 127))}, ak);
    chk("high cmd acks", 16'h0001, ak);
    for (int m = 0; m < 4; m++) begin
      tick(1);
      pwr_mode = pwr_mode_t'(m);
      seen = 1'b0;
      wr({8'h54, 8'h02}, ak);
      chk("foreign acks", 16'h0000, ak);
      chk("foreign stretch", 16'(m >= 2), 16'(seen));
    end
    pwr_mode = PWR_NORMAL;
    tick(1);
    seen = 1'b0;
    nv_busy = 1'b1;
    fork
      begin
        tick(500);
        nv_busy = 1'b0;
      end
      wr({8'haa, 8'h02, 8'h11, 8'h22}, ak);
    join
    chk("busy acks", 16'h000f, ak);
    chk("busy stretch", 16'h0001, 16'(seen));
    for (int t = 0; t < 6; t++) begin
      a = 8'($urandom_range(4, 52));
      rd(1'b0, a, t % 4 + 1, ak, q);
      chk("read acks", 16'h0007, ak);
      foreach (q[i]) chk("incr read", exp_byte(a + i), q[i]);
      wr({8'haa, a}, ak);
      rd(1'b1, 8'h00, 2, ak, q);
      chk("quick lo", exp_byte(a), q[0]);
      chk("quick hi", exp_byte(a + 1), q[1]);
    end
    rd(1'b0, 8'h7e, 2, ak, q);
    chk("top acks", 16'h0007, ak);
    chk("top bytes", 16'h0000, {q[0], q[1]});
    fork
      host.hold_sda(int'(CYC) * 10 + 5000);
      begin
        tick(int'(CYC) + 300);
        chk("stuck sda", 16'h0000, 16'(sda_oe));
        chk("stuck scl", 16'h0000, 16'(scl_oe));
        chk("stuck sleep", 16'h0001, 16'(engine_sleep));
        chk("open drain outs", 16'h0000, 16'({scl_out, sda_out}));
      end
    join
    tick(20);
    print_verdict();
  end
endmodule : gauge_i2c_command_port_tb
